// [cal_pkg.sv]
// shared types and constants for the calibration engine
package cal_pkg;
  localparam int unsigned GAIN_W       = 16;
  localparam int unsigned MEAS_W       = 32;
  localparam int unsigned RANGE_W      = 5;
  localparam int unsigned PHASE_W      = 8;
  localparam logic [31:0] GAIN_MIN     = 32'h0000_61a8;
  localparam logic [31:0] GAIN_MAX     = 32'h0000_ffff;
  localparam int unsigned SAMPLES_LINE = 56;
  localparam int unsigned PHASE_STEPS  = 256;
  localparam logic [15:0] GAIN_RST     = 16'h8000;
  localparam logic [15:0] FREQ_MIN_MHZ = 16'hafc8;
  localparam logic [15:0] FREQ_MAX_MHZ = 16'hfde8;
  localparam int unsigned DIV_CYCLES   = 48;
  localparam logic [1:0]  SEL_CH1      = 2'h1;
  localparam logic [1:0]  SEL_CH2      = 2'h2;
  localparam logic [1:0]  SEL_BOTH     = 2'h3;

  typedef enum logic [1:0] {Q_IRMS1, Q_IRMS2, Q_VRMS, Q_P1} qty_unused_e;

  typedef struct packed {
    logic [15:0] irms1;
    logic [15:0] irms2;
    logic [15:0] vrms;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [15:0] freq;
  } gain_set_s;

  typedef struct packed {
    logic [31:0] irms1;
    logic [31:0] irms2;
    logic [31:0] vrms;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] freq;
  } meas_set_s;

  typedef struct packed {
    logic [15:0] irms;
    logic [15:0] p;
    logic [15:0] q;
  } offset_s;
endpackage

// [ratio_div.sv]
// sequential divider for old gain times expected over measured
`timescale 1ns/1ps
module ratio_div #(
  parameter int unsigned NW = 48,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  input  wire logic          start_i,
  input  wire logic [NW-1:0] num_i,
  input  wire logic [DW-1:0] den_i,
  output logic               done_o,
  output logic [NW-1:0]      quot_o
);
  logic [NW-1:0]   num_reg;
  logic [DW:0]     rem_reg;
  logic [7:0]      cnt_reg;
  logic            busy_reg;
  logic [DW:0]     rem_sh;
  assign rem_sh = {rem_reg[DW-1:0], num_reg[NW-1]};

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      num_reg  <= '0;
      rem_reg  <= '0;
      cnt_reg  <= 8'h00;
      busy_reg <= 1'b0;
      done_o   <= 1'b0;
      quot_o   <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_reg) begin
        num_reg  <= num_i;
        rem_reg  <= '0;
        cnt_reg  <= 8'(NW);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        // restoring step, quotient truncates
        if (rem_sh >= {1'b0, den_i}) begin
          rem_reg <= rem_sh - {1'b0, den_i};
          num_reg <= {num_reg[NW-2:0], 1'b1};
        end else begin
          rem_reg <= rem_sh;
          num_reg <= {num_reg[NW-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          busy_reg <= 1'b0;
          done_o   <= 1'b1;
          quot_o   <= (rem_sh >= {1'b0, den_i}) ? {num_reg[NW-2:0], 1'b1}
                                                 : {num_reg[NW-2:0], 1'b0};
        end
      end
    end
  end
endmodule

// [cal_engine.sv]
// calibration gain, range, phase, offset and line frequency engine
//
// Functional notes
// - gain calibration: new gain is old gain times expected over measured
// - result below 25000 or above 65535, or a zero measured value, answers nak, otherwise ack
// - after gain multiply the value shifts right by the range setting
// - each current channel keeps and outputs its own phase setting
// - 56 samples per line cycle; phase delay in sample fractions
// - signed phase, plus or minus half a sample, 256 steps per sample
// - phase taken as signed low byte of the 16-bit register
// - writable ac offsets for irms, active, reactive power per channel
// - line frequency reported as a 16-bit value
// - line frequency valid only from 45 to 65 hz
// - frequency calibration updates only line frequency gain
// - gain calibration updates current and power gains per selection, voltage gain always
// - ack only when all selected gains lie in the window
`timescale 1ns/1ps
module cal_engine (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   cal_gain_i,
  input  wire logic                   cal_freq_i,
  input  wire logic [1:0]             chan_sel_i,
  input  wire cal_pkg::meas_set_s     expected_i,
  input  wire cal_pkg::meas_set_s     measured_i,
  input  wire logic [15:0]            line_freq_reference_i,
  input  wire logic                   gain_wr_i,
  input  wire cal_pkg::gain_set_s     gain_wr_data_i,
  input  wire logic                   range_wr_i,
  input  wire logic [4:0]             range_i_data_i,
  input  wire logic                   phase_wr_i,
  input  wire logic [15:0]            phase1_data_i,
  input  wire logic [15:0]            phase2_data_i,
  input  wire logic                   offset_wr_i,
  input  wire cal_pkg::offset_s       offset1_data_i,
  input  wire cal_pkg::offset_s       offset2_data_i,
  input  wire logic [15:0]            line_freq_raw_i,
  input  wire logic                   path_valid_i,
  input  wire logic [31:0]            path_raw_i,
  input  wire logic [2:0]             path_sel_i,
  output logic                        busy_o,
  output logic                        ack_o,
  output logic                        nak_o,
  output cal_pkg::gain_set_s          gains_o,
  output logic [4:0]                  range_o,
  output logic signed [7:0]           phase1_o,
  output logic signed [7:0]           phase2_o,
  output cal_pkg::offset_s            offset1_o,
  output cal_pkg::offset_s            offset2_o,
  output logic [15:0]                 line_freq_o,
  output logic                        line_freq_valid_o,
  output logic                        path_valid_o,
  output logic signed [33:0]          path_out_o
);
  import cal_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WAIT, S_NEXT, S_DONE} st_e;

  // ==========================================================
  // state
  // ==========================================================
  st_e             st_reg;
  gain_set_s       new_gain_reg;
  logic [2:0]      idx_reg;
  logic            freq_mode_reg;
  logic [1:0]      sel_reg;
  logic            fail_reg;
  logic            start_reg;
  logic [47:0]     num_w;
  logic [31:0]     den_w;
  logic            div_done;
  logic [47:0]     quot_w;
  logic [15:0]     old_g;
  logic [31:0]     exp_w;
  logic            idx_en;

  // ==========================================================
  // operand select
  // ==========================================================
  always_comb begin
    unique case (idx_reg)
      3'h0: begin old_g = gains_o.irms1; exp_w = expected_i.irms1; den_w = measured_i.irms1; end
      3'h1: begin old_g = gains_o.irms2; exp_w = expected_i.irms2; den_w = measured_i.irms2; end
      3'h2: begin old_g = gains_o.vrms;  exp_w = expected_i.vrms;  den_w = measured_i.vrms;  end
      3'h3: begin old_g = gains_o.p1;    exp_w = expected_i.p1;    den_w = measured_i.p1;    end
      3'h4: begin old_g = gains_o.p2;    exp_w = expected_i.p2;    den_w = measured_i.p2;    end
      default: begin
        old_g = gains_o.freq;
        exp_w = {16'h0000, line_freq_reference_i};
        den_w = measured_i.freq;
      end
    endcase
  end
  assign num_w = 48'(old_g) * 48'(exp_w);

  // which quantities the selection covers
  always_comb begin
    unique case (idx_reg)
      3'h0, 3'h3: idx_en = sel_reg[0];
      3'h1, 3'h4: idx_en = sel_reg[1];
      default:    idx_en = 1'b1;
    endcase
  end

  ratio_div #(.NW(48), .DW(32)) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (start_reg),
    .num_i     (num_w),
    .den_i     (den_w),
    .done_o    (div_done),
    .quot_o    (quot_w)
  );

  // ==========================================================
  // calibration sequencer
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg        <= S_IDLE;
      idx_reg       <= 3'h0;
      freq_mode_reg <= 1'b0;
      sel_reg       <= 2'h0;
      fail_reg      <= 1'b0;
      start_reg     <= 1'b0;
      new_gain_reg  <= '0;
    end else begin
      start_reg <= 1'b0;
      unique case (st_reg)
        S_IDLE: begin
          if (cal_freq_i) begin
            freq_mode_reg <= 1'b1;
            idx_reg       <= 3'h5;
            fail_reg      <= 1'b0;
            new_gain_reg  <= gains_o;
            st_reg        <= S_LOAD;
          end else if (cal_gain_i) begin
            freq_mode_reg <= 1'b0;
            sel_reg       <= chan_sel_i;
            idx_reg       <= 3'h0;
            fail_reg      <= 1'b0;
            new_gain_reg  <= gains_o;
            st_reg        <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (!idx_en) begin
            st_reg <= S_NEXT;
          end else if (den_w == 32'h0) begin
            fail_reg <= 1'b1;
            st_reg   <= S_NEXT;
          end else begin
            start_reg <= 1'b1;
            st_reg    <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (div_done) begin
            // full-width check before narrowing
            if (quot_w < 48'(GAIN_MIN) || quot_w > 48'(GAIN_MAX)) begin
              fail_reg <= 1'b1;
            end
            unique case (idx_reg)
              3'h0: new_gain_reg.irms1 <= quot_w[15:0];
              3'h1: new_gain_reg.irms2 <= quot_w[15:0];
              3'h2: new_gain_reg.vrms  <= quot_w[15:0];
              3'h3: new_gain_reg.p1    <= quot_w[15:0];
              3'h4: new_gain_reg.p2    <= quot_w[15:0];
              default: new_gain_reg.freq <= quot_w[15:0];
            endcase
            st_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (freq_mode_reg || idx_reg == 3'h4) begin
            st_reg <= S_DONE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
            st_reg  <= S_LOAD;
          end
        end
        S_DONE: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  assign busy_o = (st_reg != S_IDLE);

  // ==========================================================
  // answer
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      nak_o <= 1'b0;
    end else begin
      ack_o <= (st_reg == S_DONE) && !fail_reg;
      nak_o <= (st_reg == S_DONE) && fail_reg;
    end
  end

  // ==========================================================
  // gain registers
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gains_o <= {6{GAIN_RST}};
    end else if (st_reg == S_DONE) begin
      if (!fail_reg) begin
        gains_o <= new_gain_reg;
      end
    end else if (gain_wr_i && st_reg == S_IDLE) begin
      gains_o <= gain_wr_data_i;
    end
  end

  // ==========================================================
  // range, phase, offset registers
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      range_o <= 5'h00;
    end else if (range_wr_i) begin
      range_o <= range_i_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase1_o <= 8'sh00;
      phase2_o <= 8'sh00;
    end else if (phase_wr_i) begin
      phase1_o <= signed'(phase1_data_i[7:0]);
      phase2_o <= signed'(phase2_data_i[7:0]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      offset1_o <= '0;
      offset2_o <= '0;
    end else if (offset_wr_i) begin
      offset1_o <= offset1_data_i;
      offset2_o <= offset2_data_i;
    end
  end

  // ==========================================================
  // gain and range datapath with offset
  // ==========================================================
  logic [15:0]        pg;
  logic signed [16:0] po;
  logic [47:0]        prod;
  always_comb begin
    unique case (path_sel_i)
      3'h0: begin pg = gains_o.irms1; po = 17'(signed'(offset1_o.irms)); end
      3'h1: begin pg = gains_o.irms2; po = 17'(signed'(offset2_o.irms)); end
      3'h2: begin pg = gains_o.p1;    po = 17'(signed'(offset1_o.p));    end
      3'h3: begin pg = gains_o.p2;    po = 17'(signed'(offset2_o.p));    end
      3'h4: begin pg = gains_o.p1;    po = 17'(signed'(offset1_o.q));    end
      3'h5: begin pg = gains_o.p2;    po = 17'(signed'(offset2_o.q));    end
      default: begin pg = gains_o.vrms; po = 17'sh00000; end
    endcase
  end
  assign prod = (48'(path_raw_i) * 48'(pg)) >> range_o;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      path_valid_o <= 1'b0;
      path_out_o   <= '0;
    end else begin
      path_valid_o <= path_valid_i;
      if (path_valid_i) begin
        path_out_o <= signed'({1'b0, prod[32:0]}) + 34'(po);
      end
    end
  end

  // ==========================================================
  // line frequency
  // ==========================================================
  logic [15:0] lf_meta_reg, lf_sync_reg, lf_hold_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lf_meta_reg       <= 16'h0000;
      lf_sync_reg       <= 16'h0000;
      lf_hold_reg       <= 16'h0000;
      line_freq_o       <= 16'h0000;
      line_freq_valid_o <= 1'b0;
    end else begin
      lf_meta_reg       <= line_freq_raw_i;
      lf_sync_reg       <= lf_meta_reg;
      lf_hold_reg       <= lf_sync_reg;
      if (lf_sync_reg == lf_hold_reg) begin
        line_freq_o       <= lf_sync_reg;
        line_freq_valid_o <= lf_sync_reg >= FREQ_MIN_MHZ && lf_sync_reg <= FREQ_MAX_MHZ;
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence done_ok_s;
    (st_reg == S_DONE) && !fail_reg;
  endsequence
  sequence done_bad_s;
    (st_reg == S_DONE) && fail_reg;
  endsequence

  ack_on_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done_ok_s |=> ack_o && !nak_o) else $error("ack missing");
  nak_on_fail_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done_bad_s |=> nak_o && !ack_o) else $error("nak missing");
  gain_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done_bad_s |=> $stable(gains_o)) else $error("gain changed on nak");
  gain_commit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done_ok_s |=> gains_o == $past(new_gain_reg)) else $error("gain not committed");
  out_of_window_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg == S_WAIT && div_done && quot_w > 48'(GAIN_MAX)) |=> fail_reg)
    else $error("over range accepted");
  freq_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg == S_DONE && freq_mode_reg && !fail_reg)
      |=> gains_o[95:16] == $past(gains_o[95:16])) else $error("freq cal touched others");
  phase_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    phase_wr_i |=> phase1_o == $past(phase1_data_i[7:0])) else $error("phase byte wrong");
  range_shift_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (path_valid_i && range_o == 5'h1f && !range_wr_i && path_sel_i == 3'h7)
      |=> path_out_o < 34'sh0_0002_0000) else $error("range shift missing");
  freq_valid_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    line_freq_valid_o |-> line_freq_o >= FREQ_MIN_MHZ && line_freq_o <= FREQ_MAX_MHZ)
    else $error("invalid frequency flagged valid");
  ack_bounded_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg == S_IDLE && cal_freq_i) |-> ##[1:60] (st_reg == S_DONE)) else $error("cal hung");
endmodule

// [cal_host_model.sv]
// host model that issues calibration, phase and save commands
`timescale 1ns/1ps
module cal_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        ack_i,
  input  wire logic        nak_i,
  output logic             cal_gain_o,
  output logic             cal_freq_o,
  output logic [1:0]       chan_sel_o,
  output logic             phase_wr_o,
  output logic [15:0]      phase1_o,
  output logic [15:0]      phase2_o,
  output logic             save_o,
  output logic             timeout_o
);
  initial begin
    cal_gain_o = 1'b0;
    cal_freq_o = 1'b0;
    chan_sel_o = 2'h0;
    phase_wr_o = 1'b0;
    phase1_o   = 16'h0;
    phase2_o   = 16'h0;
    save_o     = 1'b0;
    timeout_o  = 1'b0;
  end
  // ==========================================================
  // one command, then wait for its answer
  task automatic cal(input logic freq, input logic [1:0] sel);
    int n;
    @(posedge clk_sys_i);
    #1;
    cal_gain_o = ~freq;
    cal_freq_o = freq;
    chan_sel_o = sel;
    @(posedge clk_sys_i);
    #1;
    cal_gain_o = 1'b0;
    cal_freq_o = 1'b0;
    n = 0;
    while (!(ack_i === 1'b1 || nak_i === 1'b1) && n < 1000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 1000) timeout_o = 1'b1;
    if (ack_i === 1'b1) save_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    save_o = 1'b0;
  endtask
  // ==========================================================
  // phase update: old value plus angle error times 40
  task automatic phase_adj(input logic [7:0] o1, input logic [7:0] o2,
                           input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk_sys_i);
    #1;
    phase1_o   = {8'ha5, 8'(o1 + e1 * 8'd40)};
    phase2_o   = {8'h5a, 8'(o2 + e2 * 8'd40)};
    phase_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    phase_wr_o = 1'b0;
  endtask
endmodule

// [calibration_gain_phase_engine_tb_top.sv]
// self-checking bench for the calibration engine
`timescale 1ns/1ps
module calibration_gain_phase_engine_tb_top;
  import cal_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i;
  logic        cal_gain_i, cal_freq_i, phase_wr_i, save, host_to;
  logic        gain_wr_i, range_wr_i, offset_wr_i, path_valid_i;
  logic        busy_o, ack_o, nak_o, line_freq_valid_o, path_valid_o;
  logic [1:0]  chan_sel_i;
  logic [2:0]  path_sel_i;
  logic [4:0]  range_i_data_i, range_o;
  logic [15:0] phase1_data_i, phase2_data_i, line_freq_reference_i, line_freq_raw_i;
  logic [15:0] line_freq_o;
  logic [31:0] path_raw_i;
  logic signed [7:0]  phase1_o, phase2_o;
  logic signed [33:0] path_out_o;
  meas_set_s   exp_v, meas_v;
  gain_set_s   gain_wr_data_i, gm, gains_o;
  offset_s     offset1_data_i, offset2_data_i, offset1_o, offset2_o;
  int          err_total = 0;
  int          tests_run = 0;
  int          seed;
  logic [96:0] cal_q [$];
  logic [96:0] ce;
  logic [33:0] path_q [$];
  int          ex [6] = '{1000, 1000, 10000, 10000, 3, 5};
  int          ms [6] = '{2300, 1150, 2300, 9200, 1, 0};
  int          lf [5] = '{50000, 44999, 45000, 65000, 65001};

  always #20 clk_sys_i = ~clk_sys_i;

  cal_engine DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cal_gain_i(cal_gain_i),
    .cal_freq_i(cal_freq_i), .chan_sel_i(chan_sel_i), .expected_i(exp_v),
    .measured_i(meas_v), .line_freq_reference_i(line_freq_reference_i),
    .gain_wr_i(gain_wr_i), .gain_wr_data_i(gain_wr_data_i), .range_wr_i(range_wr_i),
    .range_i_data_i(range_i_data_i), .phase_wr_i(phase_wr_i),
    .phase1_data_i(phase1_data_i), .phase2_data_i(phase2_data_i),
    .offset_wr_i(offset_wr_i), .offset1_data_i(offset1_data_i),
    .offset2_data_i(offset2_data_i), .line_freq_raw_i(line_freq_raw_i),
    .path_valid_i(path_valid_i), .path_raw_i(path_raw_i), .path_sel_i(path_sel_i),
    .busy_o(busy_o), .ack_o(ack_o), .nak_o(nak_o), .gains_o(gains_o),
    .range_o(range_o), .phase1_o(phase1_o), .phase2_o(phase2_o),
    .offset1_o(offset1_o), .offset2_o(offset2_o), .line_freq_o(line_freq_o),
    .line_freq_valid_o(line_freq_valid_o), .path_valid_o(path_valid_o),
    .path_out_o(path_out_o));

  cal_host_model u_host (.clk_sys_i(clk_sys_i), .ack_i(ack_o), .nak_i(nak_o),
    .cal_gain_o(cal_gain_i), .cal_freq_o(cal_freq_i), .chan_sel_o(chan_sel_i),
    .phase_wr_o(phase_wr_i), .phase1_o(phase1_data_i), .phase2_o(phase2_data_i),
    .save_o(save), .timeout_o(host_to));

  // ==========================================================
  // compare, verdict
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // gain prediction: {in window, value}
  function automatic logic [16:0] newg(logic [15:0] o, logic [31:0] e, logic [31:0] m);
    logic [63:0] r;
    if (m == 32'h0) return 17'h0;
    r = 64'(o) * 64'(e) / 64'(m);
    return {(r >= 64'd25000 && r <= 64'd65535), r[15:0]};
  endfunction
  task automatic run_cal(input logic freq, input logic [1:0] sel);
    logic [16:0] r [6];
    logic        ok;
    gain_set_s   g;
    r[0] = newg(gm.irms1, exp_v.irms1, meas_v.irms1);
    r[1] = newg(gm.irms2, exp_v.irms2, meas_v.irms2);
    r[2] = newg(gm.vrms, exp_v.vrms, meas_v.vrms);
    r[3] = newg(gm.p1, exp_v.p1, meas_v.p1);
    r[4] = newg(gm.p2, exp_v.p2, meas_v.p2);
    r[5] = newg(gm.freq, {16'h0, line_freq_reference_i}, meas_v.freq);
    g = gm;
    ok = r[5][16];
    g.freq = r[5][15:0];
    if (!freq) begin
      g = gm;
      ok = r[2][16] && (!sel[0] || (r[0][16] && r[3][16]))
           && (!sel[1] || (r[1][16] && r[4][16]));
      g.vrms = r[2][15:0];
      if (sel[0]) g.irms1 = r[0][15:0];
      if (sel[0]) g.p1 = r[3][15:0];
      if (sel[1]) g.irms2 = r[1][15:0];
      if (sel[1]) g.p2 = r[4][15:0];
    end
    if (ok) gm = g;
    cal_q.push_back({ok, gm});
    u_host.cal(freq, sel);
    if (host_to) chk("answer timeout", 1, 0);
    if (host_to) end_sim();
  endtask
  task automatic path(input logic [2:0] s, input logic [31:0] raw);
    logic [15:0] gs [8];
    logic [15:0] os [8];
    logic [63:0] x;
    gs = '{gm.irms1, gm.irms2, gm.p1, gm.p2, gm.p1, gm.p2, gm.vrms, gm.vrms};
    os = '{offset1_data_i.irms, offset2_data_i.irms, offset1_data_i.p,
           offset2_data_i.p, offset1_data_i.q, offset2_data_i.q, 16'h0, 16'h0};
    x = ((64'(raw) * 64'(gs[s])) >> range_i_data_i) + 64'(os[s]);
    path_q.push_back(x[33:0]);
    @(posedge clk_sys_i);
    #1;
    path_valid_i = 1'b1;
    path_sel_i = s;
    path_raw_i = raw;
  endtask
  // ==========================================================
  // result watcher
  always @(posedge clk_sys_i) begin
    #2;
    if (ack_o === 1'b1 || nak_o === 1'b1) begin
      ce = (cal_q.size() > 0) ? cal_q.pop_front() : 97'h0;
      chk("ack", ce[96], ack_o);
      chk("nak", !ce[96], nak_o);
      chk("gains", ce[95:0], gains_o);
    end
    if (path_valid_o === 1'b1) begin
      chk("path_out", (path_q.size() > 0) ? path_q.pop_front() : 34'h0, path_out_o);
    end
  end
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    chk("watchdog", 1, 0);
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h2a4eaf73;
    rst_b_i = 1'b0;
    {gain_wr_i, range_wr_i, offset_wr_i, path_valid_i} = 4'h0;
    {path_sel_i, path_raw_i, range_i_data_i} = '0;
    {offset1_data_i, offset2_data_i} = '0;
    line_freq_reference_i = 16'd50000;
    line_freq_raw_i = 16'd50000;
    exp_v = {6{32'd1000}};
    meas_v = {6{32'd1000}};
    gm = {16'd33480, 16'd33480, 16'd33480, 16'd33480, 16'd33480, 16'd33480};
    gain_wr_data_i = gm;
    repeat (20) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    chk("reset gains", {6{GAIN_RST}}, gains_o);
    chk("reset range", 0, range_o);
    chk("reset phase", 0, {phase1_o, phase2_o});
    gain_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    gain_wr_i = 1'b0;
    chk("gain write", gm, gains_o);
    exp_v.irms2 = 32'd5000;
    for (int i = 0; i < 6; i++) begin
      exp_v.irms1 = ex[i];
      meas_v.irms1 = ms[i];
      fork
        run_cal(1'b0, SEL_CH1);
        begin
          repeat (5) @(posedge clk_sys_i);
          #1;
          chk("busy", 1, busy_o);
          gain_wr_data_i = '1;
          gain_wr_i = 1'b1;
          @(posedge clk_sys_i);
          #1;
          gain_wr_i = 1'b0;
        end
      join
    end
    meas_v.freq = 32'd49000;
    run_cal(1'b1, SEL_BOTH);
    meas_v.freq = 32'd10;
    run_cal(1'b1, SEL_BOTH);
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 6; i++) begin
        meas_v[32*i +: 32] = 32'd1000 + ($random(seed) & 32'h3ff);
        exp_v[32*i +: 32] = meas_v[32*i +: 32] * (32'd700 + ($random(seed) & 32'h3ff)) / 32'd1000;
      end
      run_cal($random(seed) & 1, 2'(1 + ($unsigned($random(seed)) % 3)));
    end
    for (int i = 0; i < 5; i++) begin
      line_freq_raw_i = lf[i];
      repeat (6) @(posedge clk_sys_i);
      #1;
      chk("line_freq", lf[i], line_freq_o);
      chk("freq_valid", lf[i] >= FREQ_MIN_MHZ && lf[i] <= FREQ_MAX_MHZ, line_freq_valid_o);
    end
    u_host.phase_adj(8'h0, 8'h0, 8'd2, -8'sd3);
    chk("phase", {8'd80, 8'h88}, {phase1_o[7:0], phase2_o[7:0]});
    u_host.phase_adj(8'd80, 8'h88, -8'sd1, 8'd1);
    chk("phase", {8'd40, 8'hb0}, {phase1_o[7:0], phase2_o[7:0]});
    for (int r = 10; r < 14; r++) begin
      offset1_data_i = 48'($random(seed)) & 48'h7fff_7fff_7fff;
      offset2_data_i = 48'($random(seed)) & 48'h7fff_7fff_7fff;
      range_i_data_i = r;
      {range_wr_i, offset_wr_i} = 2'h3;
      @(posedge clk_sys_i);
      #1;
      {range_wr_i, offset_wr_i} = 2'h0;
      chk("range", r, range_o);
      chk("offsets", {offset1_data_i, offset2_data_i}, {offset1_o, offset2_o});
      for (int s = 0; s < 7; s++) path(s, 32'($random(seed)) & 32'hfffff);
      @(posedge clk_sys_i);
      #1;
      path_valid_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
    range_i_data_i = 5'h1f;
    range_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    range_wr_i = 1'b0;
    path(3'h7, 32'hffff_ffff);
    @(posedge clk_sys_i);
    #1;
    path_valid_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("queues empty", 0, cal_q.size() + path_q.size());
    end_sim();
  end
endmodule
